//--- rtl/clock_fail_monitor_consts.svh
// Constants for the dual start-up and fail-safe clock supervisor.
// Operation
// - Dual start when its enable bit or the monitor enable bit set.
// - Start on internal clock, then primary.
// - Power-managed entry ignores the dual start enable.
// - Source changes and Sleep accepted during start.
// - Active flag shows primary clock is running.
// - Monitor enable keeps the RC oscillator running.
// - Sample clock is RC oscillator divided by 64.
// - Latch set on clock fall, cleared on sample.
// - Sample fall with latch set means failure.
// - Failure sets flag, switches to internal clock.
// - Failure clears the watchdog and its postscaler.
// - Only primary or secondary sources are monitored.
// - Fail-safe ends on reset or power-managed entry.
// - After reset, internal until primary ready; the code clears both enable bits at reset, so it starts on primary.
// - Primary never ready: stay internal, flag clear.
// - Power-managed entry selects programmed source, monitors it.
// - Failure with interrupt enabled: run internal, wake.
// - Failure with interrupt disabled: stay in mode.
// - Non-crystal modes are monitored immediately.
// - Crystal modes unmonitored until timers expire.
// - No failure interrupt if primary never starts.
// - New mode while waiting disables primary clock.
`ifndef CLK_SUP_CONSTS_SVH
`define CLK_SUP_CONSTS_SVH
`define OFS_OSC_CTL 4'h0
`define OFS_IRQ_FLAGS2 4'h4
`define OFS_CONFIG 4'h8
`define OFS_RESET_CAUSE 4'hc
`define OFS_WDT_SW 4'h2
`define OFS_WDT_SW_HI 4'h1
`define BIT_ACTIVE_FLAG 3
`define BIT_OSC_FAIL 7
`define BIT_DUAL_EN 0
`define BIT_MON_EN 1
`define BIT_IRQ_EN 5
`define BIT_SWDT_EN 0
`define RST_OSC_CTL 8'h00
`define RST_CONFIG 8'h00
`define RST_RESET_CAUSE 8'h1c
`define SAMPLE_DIV 64
`define SAMPLE_CNT_W 6
`endif

//--- rtl/clock_fail_monitor_pkg.sv
// Types shared by the clock supervisor.
package clk_sup_pkg;
  // Supervisor states.
  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_RUN = 2'b01,
    ST_FAILSAFE = 2'b10,
    ST_SLEEP = 2'b11
  } sup_state_e;
  // Clock multiplexer selection.
  typedef enum logic [1:0] {
    SRC_PRIMARY = 2'b00,
    SRC_SECONDARY = 2'b01,
    SRC_INTERNAL = 2'b10
  } clk_src_e;
  // Primary oscillator mode.
  typedef enum logic [2:0] {
    MODE_XTAL_LOW = 3'b000,
    MODE_XTAL_MED = 3'b001,
    MODE_XTAL_FAST = 3'b010,
    MODE_XTAL_PLL = 3'b011,
    MODE_EXT_CLK = 3'b100,
    MODE_RC = 3'b101,
    MODE_INT_RC = 3'b110
  } pri_mode_e;
  // Oscillator control register layout.
  typedef struct packed {
    logic rsv7;
    logic [2:0] internal_freq_select;
    logic primary_clock_active_flag;
    logic rsv2;
    logic [1:0] clock_source_select;
  } osc_ctl_s;
  // Configuration register layout.
  typedef struct packed {
    logic [1:0] rsv;
    logic fail_irq_enable;
    pri_mode_e pri_mode;
    logic clock_monitor_enable;
    logic startup_dual_clock_enable;
  } config_s;
  // Power-managed event strobes.
  typedef struct packed {
    logic pm_enter;
    logic sleep_enter;
    logic wake;
  } pm_evt_s;
endpackage : clk_sup_pkg

//--- rtl/dual_start_fail_safe_clock.sv
// Dual start-up and fail-safe clock supervisor with Avalon-MM registers.
`timescale 1ns/1ps
`include "clock_fail_monitor_consts.svh"
module dual_start_fail_safe_clock (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic NRST,
  // Avalon-MM register slave.
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Oscillator pins and timer indications.
  input wire logic IRC_OSC,
  input wire logic DEV_CLK,
  input wire logic STARTUP_DONE,
  input wire logic PLL_LOCK,
  // Power-managed mode events from the core.
  input wire clk_sup_pkg::pm_evt_s PM_EVT,
  // Clock control outputs.
  output clk_sup_pkg::clk_src_e CLK_SEL,
  output logic PRIMARY_EN,
  output logic IRC_RUN,
  output logic FAIL_SAFE,
  output logic OSC_FAIL,
  output logic PM_WAKE,
  output logic WDT_CLEAR,
  output logic SOFT_WDT_EN
);
  import clk_sup_pkg::*;

  // Synchroniser chains for pins; stage 1 is only read by stage 2.
  logic [2:0] irc_sync_q, irc_sync_d;
  logic [2:0] dev_sync_q, dev_sync_d;
  logic [1:0] tmr_sync_q, tmr_sync_d;
  logic [1:0] pll_sync_q, pll_sync_d;

  // Next values of the synchroniser chains.
  always_comb begin
    irc_sync_d = {irc_sync_q[1:0], IRC_OSC};
    dev_sync_d = {dev_sync_q[1:0], DEV_CLK};
    tmr_sync_d = {tmr_sync_q[0], STARTUP_DONE};
    pll_sync_d = {pll_sync_q[0], PLL_LOCK};
  end

  // Register the synchroniser chains.
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      irc_sync_q <= 3'h0;
      dev_sync_q <= 3'h0; // Idle low, so reset gives no false fall.
      tmr_sync_q <= 2'h0;
      pll_sync_q <= 2'h0;
    end else begin
      irc_sync_q <= irc_sync_d;
      dev_sync_q <= dev_sync_d;
      tmr_sync_q <= tmr_sync_d;
      pll_sync_q <= pll_sync_d;
    end
  end

  // Edges are taken from stages two and three only.
  logic irc_rise;
  logic dev_fall;
  assign irc_rise = irc_sync_q[1] & ~irc_sync_q[2];
  assign dev_fall = ~dev_sync_q[1] & dev_sync_q[2];

  // Registers held by the block.
  osc_ctl_s osc_ctl_q, osc_ctl_d; // Oscillator control.
  config_s cfg_q, cfg_d; // Configuration bits.
  logic fail_flag_q, fail_flag_d; // Oscillator fail flag.
  logic [7:0] rcause_q, rcause_d; // Reset cause control.
  logic swdt_q, swdt_d; // Software watchdog enable.
  logic ack_q, ack_d; // Bus answer cycle.
  logic [31:0] rdata_q, rdata_d; // Registered read data.

  // Monitor state.
  sup_state_e state_q, state_d; // Supervisor state.
  clk_src_e src_q, src_d; // Source used outside fail-safe.
  logic prim_en_q, prim_en_d; // Primary oscillator enable.
  logic [`SAMPLE_CNT_W-1:0] div_q, div_d; // Sample clock divider.
  logic latch_q, latch_d; // Monitor latch.
  logic wdt_clr_q, wdt_clr_d; // Watchdog clear pulse.
  logic wake_q, wake_d; // Wake pulse on failure.

  // Decoded strobes and events.
  logic wr_en, samp_rise, samp_fall, fail_evt, monitoring, crystal, ready;
  logic ifs_change;

  // A write lands at the edge where waitrequest is low.
  assign wr_en = AVS_WRITE & ack_q;
  assign ifs_change = wr_en && AVS_ADDRESS == `OFS_OSC_CTL &&
    AVS_WRITEDATA[6:4] != osc_ctl_q.internal_freq_select;
  // Sample clock is the divider MSB; rises at 31 to 32, falls at 63 to 0.
  assign samp_rise = irc_rise && div_q == 6'h1f;
  assign samp_fall = irc_rise && div_q == 6'h3f;
  assign crystal = cfg_q.pri_mode inside {MODE_XTAL_LOW, MODE_XTAL_MED,
    MODE_XTAL_FAST, MODE_XTAL_PLL};
  // Primary is ready on start-up timer expiry and, in PLL mode, lock.
  assign ready = tmr_sync_q[1] &&
    (cfg_q.pri_mode != MODE_XTAL_PLL || pll_sync_q[1]);
  // Only a running primary or secondary source is watched.
  assign monitoring = cfg_q.clock_monitor_enable && state_q == ST_RUN &&
    src_q != SRC_INTERNAL;
  assign fail_evt = monitoring && samp_fall && latch_q;

  // Divider and monitor latch next values.
  always_comb begin
    div_d = div_q;
    if (irc_rise) begin
      div_d = div_q + 6'h01;
    end
    latch_d = latch_q;
    if (samp_rise) begin
      latch_d = 1'b0;
    end
    if (dev_fall) begin
      latch_d = 1'b1;
    end
  end

  // Supervisor state machine next values.
  always_comb begin
    state_d = state_q;
    src_d = src_q;
    prim_en_d = prim_en_q;
    wdt_clr_d = ifs_change;
    wake_d = 1'b0;
    osc_ctl_d = osc_ctl_q;
    fail_flag_d = fail_flag_q;
    case (state_q)
      // Waiting for the primary after reset or wake.
      ST_START: begin
        if (PM_EVT.sleep_enter) begin
          state_d = ST_SLEEP;
          prim_en_d = 1'b0;
        end else if (PM_EVT.pm_enter) begin
          state_d = ST_RUN;
          prim_en_d = 1'b0;
          src_d = clk_src_e'(osc_ctl_q.clock_source_select[1] ?
            SRC_INTERNAL : {1'b0, osc_ctl_q.clock_source_select[0]});
        end else if (ready) begin
          state_d = ST_RUN;
          src_d = SRC_PRIMARY;
          osc_ctl_d.primary_clock_active_flag = 1'b1;
        end
      end
      // Running from the chosen source with monitoring.
      ST_RUN: begin
        if (fail_evt) begin
          state_d = ST_FAILSAFE;
          wdt_clr_d = 1'b1;
          wake_d = cfg_q.fail_irq_enable;
        end else if (PM_EVT.sleep_enter) begin
          state_d = ST_SLEEP;
        end else if (PM_EVT.pm_enter) begin
          src_d = clk_src_e'(osc_ctl_q.clock_source_select[1] ?
            SRC_INTERNAL : {1'b0, osc_ctl_q.clock_source_select[0]});
          prim_en_d = osc_ctl_q.clock_source_select == 2'b00;
        end
      end
      // Fail-safe: internal clock until a power-managed entry.
      ST_FAILSAFE: begin
        if (PM_EVT.sleep_enter) begin
          state_d = ST_SLEEP;
        end else if (PM_EVT.pm_enter) begin
          state_d = ST_RUN;
          src_d = clk_src_e'(osc_ctl_q.clock_source_select[1] ?
            SRC_INTERNAL : {1'b0, osc_ctl_q.clock_source_select[0]});
          prim_en_d = osc_ctl_q.clock_source_select == 2'b00;
        end
      end
      // Sleep: wait for a wake event.
      ST_SLEEP: begin
        if (PM_EVT.wake) begin
          prim_en_d = 1'b1;
          src_d = SRC_PRIMARY;
          osc_ctl_d.primary_clock_active_flag = ~crystal;
          state_d = crystal ? ST_START : ST_RUN;
        end
      end
      default: begin
        state_d = ST_START;
      end
    endcase
    wdt_clr_d = wdt_clr_d | (wr_en && AVS_ADDRESS == `OFS_WDT_SW_HI);
    // Software register writes.
    if (wr_en && AVS_ADDRESS == `OFS_OSC_CTL) begin
      osc_ctl_d.internal_freq_select = AVS_WRITEDATA[6:4];
      osc_ctl_d.clock_source_select = AVS_WRITEDATA[1:0];
    end
    // Writing zero clears the flag; a failure in that cycle wins.
    if (wr_en && AVS_ADDRESS == `OFS_IRQ_FLAGS2 &&
        !AVS_WRITEDATA[`BIT_OSC_FAIL]) begin
      fail_flag_d = 1'b0;
    end
    if (fail_evt) begin
      fail_flag_d = 1'b1;
    end
  end

  // Configuration, reset cause and bus answer next values.
  always_comb begin
    cfg_d = cfg_q;
    rcause_d = rcause_q;
    swdt_d = swdt_q;
    ack_d = (AVS_READ | AVS_WRITE) & ~ack_q;
    rdata_d = rdata_q;
    if (wr_en && AVS_ADDRESS == `OFS_CONFIG) begin
      cfg_d = config_s'({2'b00, AVS_WRITEDATA[5:0]});
    end
    if (wr_en && AVS_ADDRESS == `OFS_RESET_CAUSE) begin
      rcause_d = AVS_WRITEDATA[7:0];
    end
    if (wr_en && AVS_ADDRESS == `OFS_WDT_SW) begin
      swdt_d = AVS_WRITEDATA[`BIT_SWDT_EN];
    end
    // Read data is captured in the wait cycle; unmapped reads give zero.
    if (AVS_READ && !ack_q) begin
      case (AVS_ADDRESS)
        `OFS_OSC_CTL: rdata_d = {24'h0, osc_ctl_q};
        `OFS_IRQ_FLAGS2: rdata_d = {24'h0, fail_flag_q, 7'h00};
        `OFS_CONFIG: rdata_d = {24'h0, cfg_q};
        `OFS_RESET_CAUSE: rdata_d = {24'h0, rcause_q};
        `OFS_WDT_SW: rdata_d = {31'h0, swdt_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // Register all state.
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_START;
      src_q <= SRC_PRIMARY;
      prim_en_q <= 1'b1;
      div_q <= '0;
      latch_q <= 1'b0;
      wdt_clr_q <= 1'b0;
      wake_q <= 1'b0;
      osc_ctl_q <= osc_ctl_s'(`RST_OSC_CTL);
      cfg_q <= config_s'(`RST_CONFIG);
      fail_flag_q <= 1'b0;
      rcause_q <= `RST_RESET_CAUSE;
      swdt_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      src_q <= src_d;
      prim_en_q <= prim_en_d;
      div_q <= div_d;
      latch_q <= latch_d;
      wdt_clr_q <= wdt_clr_d;
      wake_q <= wake_d;
      osc_ctl_q <= osc_ctl_d;
      cfg_q <= cfg_d;
      fail_flag_q <= fail_flag_d;
      rcause_q <= rcause_d;
      swdt_q <= swdt_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // Clock selection: internal while starting with dual start or monitor.
  always_comb begin
    case (state_q)
      ST_START: CLK_SEL = (cfg_q.startup_dual_clock_enable |
        cfg_q.clock_monitor_enable) ? SRC_INTERNAL : SRC_PRIMARY;
      ST_FAILSAFE: CLK_SEL = SRC_INTERNAL;
      default: CLK_SEL = src_q;
    endcase
  end

  // Output drive.
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
  assign AVS_READDATA = rdata_q;
  assign PRIMARY_EN = prim_en_q;
  assign IRC_RUN = cfg_q.clock_monitor_enable | (state_q == ST_START);
  assign FAIL_SAFE = state_q == ST_FAILSAFE;
  assign OSC_FAIL = fail_flag_q;
  assign PM_WAKE = wake_q;
  assign WDT_CLEAR = wdt_clr_q;
  assign SOFT_WDT_EN = swdt_q;

  // A failure raises the flag and the watchdog clear next cycle.
  property p_fail_flag;
    @(posedge CLOCK) disable iff (!NRST)
    fail_evt |=> OSC_FAIL && WDT_CLEAR && FAIL_SAFE;
  endproperty
  a_fail_flag: assert property (p_fail_flag)
    else $error("failure did not flag, clear watchdog or enter fail-safe");

  // Fail-safe always drives the internal clock.
  property p_fs_internal;
    @(posedge CLOCK) disable iff (!NRST)
    FAIL_SAFE |-> CLK_SEL == SRC_INTERNAL;
  endproperty
  a_fs_internal: assert property (p_fs_internal)
    else $error("fail-safe not on internal clock");

  // The active flag is unchanged by a failure.
  property p_flag_kept;
    @(posedge CLOCK) disable iff (!NRST)
    fail_evt |=> $stable(osc_ctl_q.primary_clock_active_flag);
  endproperty
  a_flag_kept: assert property (p_flag_kept)
    else $error("control register changed on failure");

  // Fail-safe is left only through a power-managed entry.
  property p_fs_exit;
    @(posedge CLOCK) disable iff (!NRST)
    FAIL_SAFE && !PM_EVT.pm_enter && !PM_EVT.sleep_enter |=> FAIL_SAFE;
  endproperty
  a_fs_exit: assert property (p_fs_exit)
    else $error("fail-safe left without mode entry");

  // No failure is detected while the primary is starting.
  property p_no_start_fail;
    @(posedge CLOCK) disable iff (!NRST)
    state_q == ST_START |-> !fail_evt;
  endproperty
  a_no_start_fail: assert property (p_no_start_fail)
    else $error("failure detected during start-up");

  // Ready primary after start sets the active flag.
  property p_start_ready;
    @(posedge CLOCK) disable iff (!NRST)
    state_q == ST_START && ready && !PM_EVT.pm_enter && !PM_EVT.sleep_enter
      |=> state_q == ST_RUN && osc_ctl_q.primary_clock_active_flag;
  endproperty
  a_start_ready: assert property (p_start_ready)
    else $error("primary ready but no switch over");

  // Sample clock rises as the divider steps from 31 to 32.
  property p_sample_div;
    @(posedge CLOCK) disable iff (!NRST)
    samp_rise |-> div_q == 6'h1f ##1 (div_q == 6'h20) [*1];
  endproperty
  a_sample_div: assert property (p_sample_div)
    else $error("sample divider out of step");

  // Sample rise without a clock fall clears the latch.
  property p_latch_clear;
    @(posedge CLOCK) disable iff (!NRST)
    samp_rise && !dev_fall |=> !latch_q;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("monitor latch not cleared");

  // Mode entry while waiting drops the primary enable.
  property p_pm_disable;
    @(posedge CLOCK) disable iff (!NRST)
    state_q == ST_START && PM_EVT.pm_enter && !PM_EVT.sleep_enter
      |=> !PRIMARY_EN;
  endproperty
  a_pm_disable: assert property (p_pm_disable)
    else $error("primary still enabled after mode entry");

  // Monitor enable keeps the RC oscillator on.
  property p_irc_run;
    @(posedge CLOCK) disable iff (!NRST)
    cfg_q.clock_monitor_enable |-> IRC_RUN;
  endproperty
  a_irc_run: assert property (p_irc_run)
    else $error("RC oscillator stopped while monitoring");

  // A wake pulse only follows a failure with the interrupt enabled.
  property p_wake_src;
    @(posedge CLOCK) disable iff (!NRST)
    PM_WAKE |-> $past(fail_evt) && $past(cfg_q.fail_irq_enable);
  endproperty
  a_wake_src: assert property (p_wake_src)
    else $error("wake pulse without an enabled failure");
endmodule : dual_start_fail_safe_clock

//--- test/osc_sources_model.sv
// Behavioural model of the oscillator sources beside the supervisor.
`timescale 1ns/1ps
module osc_sources_model (
  // Requests from the supervisor.
  input wire logic irc_run,
  input wire logic pri_en,
  // Bench controls for the primary crystal.
  input wire logic dev_run,
  input wire logic tmr_ok,
  // Oscillator outputs and timer levels.
  output logic irc_osc,
  output logic dev_clk,
  output logic tmr_done,
  output logic pll_lock
);
  // The RC oscillator runs only while requested, with a 200 ns period.
  initial irc_osc = 1'b0;
  always begin
    #100;
    irc_osc = irc_run ? ~irc_osc : 1'b0;
  end
  // A disabled or stalled crystal stops with its output low.
  initial dev_clk = 1'b0;
  always begin
    #50;
    dev_clk = (dev_run && pri_en) ? ~dev_clk : 1'b0;
  end
  // Timer expiry and lock drop while the crystal is disabled.
  assign tmr_done = tmr_ok & pri_en;
  assign pll_lock = tmr_ok & pri_en;
endmodule : osc_sources_model

//--- test/dual_start_fail_safe_clock_tb.sv
// Self-checking bench for the dual start and fail-safe supervisor.
`timescale 1ns/1ps
module dual_start_fail_safe_clock_tb;
  import clk_sup_pkg::*;
  // One table row: direction, index, write data, expected byte.
  typedef struct packed {
    logic wr;
    logic [3:0] a;
    logic [31:0] d;
    logic [7:0] e;
  } row_s;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_rq;
  logic irc, dclk, tmr, pll;
  pm_evt_s pm = '0;
  clk_src_e sel;
  logic pri_en, irc_run, fsafe, ofail, wake, wclr, swdt;
  logic dev_run = 1'b0;
  logic tmr_ok = 1'b0;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int clr_n = 0;
  int wake_n = 0;
  int n0, n1;
  logic [31:0] q;
  row_s rows [12];
  // The clock toggles every half period of 12.5 ns.
  always #12.5 clock = ~clock;
  // Design under test.
  dual_start_fail_safe_clock dut (.CLOCK(clock), .NRST(nrst),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_rq),
    .IRC_OSC(irc), .DEV_CLK(dclk), .STARTUP_DONE(tmr), .PLL_LOCK(pll),
    .PM_EVT(pm), .CLK_SEL(sel), .PRIMARY_EN(pri_en), .IRC_RUN(irc_run),
    .FAIL_SAFE(fsafe), .OSC_FAIL(ofail), .PM_WAKE(wake),
    .WDT_CLEAR(wclr), .SOFT_WDT_EN(swdt));
  // Oscillator sources on the far side.
  osc_sources_model osc (.irc_run(irc_run), .pri_en(pri_en),
    .dev_run(dev_run), .tmr_ok(tmr_ok), .irc_osc(irc), .dev_clk(dclk),
    .tmr_done(tmr), .pll_lock(pll));
  // Counts one-cycle pulses and cuts a hang short.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (wclr === 1'b1) clr_n <= clr_n + 1;
    if (wake === 1'b1) wake_n <= wake_n + 1;
    if (cyc == 30000) begin
      errors = errors + 1;
      stop_test();
    end
  end
  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // Compares a register or count value.
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_reg
  // Compares a single output level.
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: level %b want %b", $time, got, exp);
    end
  endtask : chk_bit
  // One bus access, held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int n = 0;
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wait_rq !== 1'b0 && n < 40);
    if (n >= 40) errors++;
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clock);
  endtask : bus
  // Reads a register and compares it.
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk_reg(r, e);
  endtask : rd_chk
  // Sends one power-managed event pulse.
  task automatic pulse(input pm_evt_s v);
    pm <= v;
    @(posedge clock);
    pm <= '0;
    @(posedge clock);
  endtask : pulse
  // Waits a bounded time for the multiplexer to pick a source.
  task automatic wait_sel(input clk_src_e s);
    int n = 0;
    while (sel !== s && n < 40) begin
      @(posedge clock);
      n++;
    end
  endtask : wait_sel
  // Waits a bounded time for the failure flag.
  task automatic wait_fail();
    int n = 0;
    while (ofail !== 1'b1 && n < 1500) begin
      @(posedge clock);
      n++;
    end
  endtask : wait_fail
  // Main sequence.
  initial begin
    rows = '{'{0, 4'h0, 0, 8'h00}, '{0, 4'hc, 0, 8'h1c},
      '{0, 4'h8, 0, 8'h00}, '{0, 4'h2, 0, 8'h00}, '{0, 4'h4, 0, 8'h00},
      '{0, 4'h3, 0, 8'h00}, '{1, 4'hc, 32'h123456a5, 0},
      '{0, 4'hc, 0, 8'ha5}, '{1, 4'h2, 32'h1, 0}, '{0, 4'h2, 0, 8'h01},
      '{1, 4'h3, 32'hff, 0}, '{0, 4'h3, 0, 8'h00}};
    repeat (3) @(posedge clock);
    chk_bit(sel === SRC_PRIMARY, 1'b1);
    chk_bit(pri_en, 1'b1);
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    // Table of register reset values and plain accesses.
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d, q);
      if (!rows[i].wr) chk_reg(q, {24'h0, rows[i].e});
    end
    chk_bit(swdt, 1'b1);
    // Clear strobes: direct write, frequency change, unchanged rewrite.
    n0 = clr_n;
    bus(1'b1, 4'h1, 32'h0, q);
    bus(1'b1, 4'h0, 32'h70, q);
    bus(1'b1, 4'h0, 32'h70, q);
    repeat (2) @(posedge clock);
    chk_reg(clr_n - n0, 2);
    // Primary not ready: no dual start, flag stays clear.
    chk_bit(sel === SRC_PRIMARY, 1'b1);
    rd_chk(4'h0, 32'h70);
    tmr_ok <= 1'b1;
    repeat (8) @(posedge clock);
    rd_chk(4'h0, 32'h78);
    // Dual start on wake from Sleep in a crystal mode.
    bus(1'b1, 4'h8, 32'h09, q);
    tmr_ok <= 1'b0;
    pulse(3'b010);
    pulse(3'b001);
    repeat (4) @(posedge clock);
    chk_bit(sel === SRC_INTERNAL, 1'b1);
    rd_chk(4'h0, 32'h70);
    tmr_ok <= 1'b1;
    wait_sel(SRC_PRIMARY);
    chk_bit(sel === SRC_PRIMARY, 1'b1);
    rd_chk(4'h0, 32'h78);
    // Dual start disabled in the PLL mode, then a new mode while waiting.
    bus(1'b1, 4'h8, 32'h0c, q);
    tmr_ok <= 1'b0;
    pulse(3'b010);
    pulse(3'b001);
    repeat (4) @(posedge clock);
    chk_bit(sel === SRC_PRIMARY, 1'b1);
    bus(1'b1, 4'h0, 32'h72, q);
    pulse(3'b100);
    repeat (4) @(posedge clock);
    chk_bit(pri_en, 1'b0);
    chk_bit(sel === SRC_INTERNAL, 1'b1);
    tmr_ok <= 1'b1;
    bus(1'b1, 4'h0, 32'h70, q);
    pulse(3'b100);
    wait_sel(SRC_PRIMARY);
    chk_bit(sel === SRC_PRIMARY, 1'b1);
    // External clock mode runs from the primary at once.
    bus(1'b1, 4'h8, 32'h10, q);
    tmr_ok <= 1'b0;
    pulse(3'b010);
    pulse(3'b001);
    repeat (4) @(posedge clock);
    rd_chk(4'h0, 32'h78);
    // Crystal start with monitoring: suppressed until the timer ends.
    bus(1'b1, 4'h8, 32'h2a, q);
    chk_bit(irc_run, 1'b1);
    dev_run <= 1'b1;
    pulse(3'b010);
    pulse(3'b001);
    repeat (1200) @(posedge clock);
    chk_bit(ofail, 1'b0);
    dev_run <= 1'b0;
    // A sample rise must empty the latch before monitoring starts.
    repeat (600) @(posedge clock);
    tmr_ok <= 1'b1;
    wait_sel(SRC_PRIMARY);
    repeat (1200) @(posedge clock);
    chk_bit(ofail, 1'b0);
    // Device clock edges reach the latch: a failure is declared.
    n0 = clr_n;
    n1 = wake_n;
    dev_run <= 1'b1;
    wait_fail();
    chk_bit(ofail, 1'b1);
    repeat (4) @(posedge clock);
    chk_bit(sel === SRC_INTERNAL, 1'b1);
    chk_bit(fsafe, 1'b1);
    rd_chk(4'h4, 32'h80);
    rd_chk(4'h0, 32'h78);
    chk_reg(clr_n - n0, 1);
    chk_reg(wake_n - n1, 1);
    // Clearing the flag does not end fail-safe; mode entry does.
    bus(1'b1, 4'h4, 32'h0, q);
    rd_chk(4'h4, 32'h0);
    chk_bit(fsafe, 1'b1);
    pulse(3'b100);
    repeat (4) @(posedge clock);
    chk_bit(fsafe, 1'b0);
    chk_bit(sel === SRC_PRIMARY, 1'b1);
    // Failure with the interrupt disabled gives no wake.
    n1 = wake_n;
    bus(1'b1, 4'h8, 32'h0a, q);
    wait_fail();
    chk_bit(ofail, 1'b1);
    repeat (4) @(posedge clock);
    chk_reg(wake_n - n1, 0);
    chk_bit(sel === SRC_INTERNAL, 1'b1);
    // A reset in mid-run ends fail-safe.
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    chk_bit(fsafe, 1'b0);
    chk_bit(ofail, 1'b0);
    rd_chk(4'h0, 32'h0);
    stop_test();
  end
endmodule : dual_start_fail_safe_clock_tb
